// ### rtl/core_regs_pkg.sv
// Purpose: Shared constants for the core register and flag unit
// Assumes: 32-bit AHB-Lite register window, one word per register
// Notes:   Op codes are what software writes into the command register

package core_regs_pkg;

  // ********************************************************
  // Vectors and memory pages
  // ********************************************************
  localparam logic [15:0] RESET_VEC   = 16'hfffe;
  localparam logic [15:0] INT0_VEC    = 16'hfffa;
  localparam logic [15:0] INT1_VEC    = 16'hfff8;
  localparam logic [15:0] TBL0_VEC    = 16'hffde;
  localparam logic [15:0] TRAP_VEC    = 16'hffde;
  localparam logic [7:0]  PAGECALL_PG = 8'hff;
  localparam logic [7:0]  STACK_PAGE  = 8'h01;

  // ********************************************************
  // Register offsets (byte addresses)
  // ********************************************************
  localparam logic [7:0] OFF_CMD    = 8'h00;
  localparam logic [7:0] OFF_STATUS = 8'h04;
  localparam logic [7:0] OFF_ACC    = 8'h08;
  localparam logic [7:0] OFF_XREG   = 8'h0c;
  localparam logic [7:0] OFF_YREG   = 8'h10;
  localparam logic [7:0] OFF_STKP   = 8'h14;
  localparam logic [7:0] OFF_PCNT   = 8'h18;
  localparam logic [7:0] OFF_FLAGS  = 8'h1c;

  // ********************************************************
  // Command word layout and flag positions
  // ********************************************************
  localparam int CMD_OP_LSB  = 0;
  localparam int CMD_OP_W    = 5;
  localparam int CMD_ARG_LSB = 8;
  localparam int CMD_ARG_W   = 16;
  localparam int FL_C = 0;
  localparam int FL_Z = 1;
  localparam int FL_I = 2;
  localparam int FL_H = 3;
  localparam int FL_B = 4;
  localparam int FL_G = 5;
  localparam int FL_V = 6;
  localparam int FL_N = 7;

  // ********************************************************
  // Operation codes
  // ********************************************************
  localparam logic [4:0] OP_STEP  = 5'h00;
  localparam logic [4:0] OP_ADC   = 5'h01;
  localparam logic [4:0] OP_SBC   = 5'h02;
  localparam logic [4:0] OP_LDA   = 5'h03;
  localparam logic [4:0] OP_ASL   = 5'h04;
  localparam logic [4:0] OP_ROL   = 5'h05;
  localparam logic [4:0] OP_MUL   = 5'h06;
  localparam logic [4:0] OP_DIV   = 5'h07;
  localparam logic [4:0] OP_BIT   = 5'h08;
  localparam logic [4:0] OP_PUSH  = 5'h09;
  localparam logic [4:0] OP_POP   = 5'h0a;
  localparam logic [4:0] OP_CALL  = 5'h0b;
  localparam logic [4:0] OP_PGCALL = 5'h0c;
  localparam logic [4:0] OP_TBCALL = 5'h0d;
  localparam logic [4:0] OP_TRAP  = 5'h0e;
  localparam logic [4:0] OP_RET   = 5'h0f;
  localparam logic [4:0] OP_RETI  = 5'h10;
  localparam logic [4:0] OP_UNMASK = 5'h11;
  localparam logic [4:0] OP_MASK   = 5'h12;
  localparam logic [4:0] OP_VCLR   = 5'h13;
  localparam logic [4:0] OP_PG1    = 5'h14;
  localparam logic [4:0] OP_PG0    = 5'h15;

  localparam logic [1:0] LAST_BYTE = 2'd2;

endpackage

// ### rtl/cpu_core_regs.sv
// Purpose: Programmer-visible registers, stack and flags of an 8-bit core
// Assumes: Memories on hclk, combinational read of the registered address
// Notes:   State advances on every second enabled hclk edge
//
// Design decisions made here: the AHB-Lite slave port and the register addresses.
`timescale 1ns/1ps

module cpu_core_regs
  import core_regs_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        ce,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  output logic      [15:0] pm_addr,
  input  wire logic [7:0]  pm_rdata,
  output logic      [15:0] dm_addr,
  output logic      [7:0]  dm_wdata,
  output logic             dm_we,
  input  wire logic [7:0]  dm_rdata,
  input  wire logic        ext_int0,
  input  wire logic        ext_int1
);

  typedef enum {ST_IDLE, ST_VEC_LO, ST_VEC_HI, ST_VEC_END,
                ST_PUSH, ST_POP_ADR, ST_POP_DAT, ST_BIT_DAT} state_t;

  state_t      state_reg;
  logic        phase_reg;
  logic        adv;
  logic [7:0]  a_reg;
  logic [7:0]  x_reg;
  logic [7:0]  y_reg;
  logic [7:0]  stk_reg;
  logic [7:0]  stk_next;
  logic [15:0] pcnt_reg;
  logic [7:0]  fl_reg;
  logic [15:0] vec_reg;
  logic [15:0] tgt_reg;
  logic [7:0]  lo_reg;
  logic [1:0]  idx_reg;
  logic [1:0]  len_reg;
  logic        one_byte_reg;
  logic        direct_reg;
  logic        irq_reg;
  logic        trap_reg;
  logic        pend_reg;
  logic [4:0]  op_reg;
  logic [15:0] arg_reg;
  logic [1:0]  i0_sync;
  logic [1:0]  i1_sync;
  logic        wr_q;
  logic [7:0]  addr_q;
  logic        ap;
  logic        idle;
  logic [31:0] rd_word;
  logic [7:0]  push_byte;
  logic [8:0]  sum9;
  logic [8:0]  dif9;
  logic [4:0]  lo_add;
  logic [4:0]  lo_sub;
  logic [15:0] prod;
  logic [15:0] quo;
  logic [15:0] rem;
  logic [7:0]  arg8;

  assign arg8 = arg_reg[7:0];
  assign idle = (state_reg == ST_IDLE) && !pend_reg;

  // ********************************************************
  // System cycle enable
  // ********************************************************
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      phase_reg <= 1'b0;
    else if (ce)
      phase_reg <= !phase_reg;
  end

  assign adv = ce && phase_reg;

  // ********************************************************
  // Interrupt pin synchronisers
  // ********************************************************
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      i0_sync <= 2'b00;
      i1_sync <= 2'b00;
    end
    else if (ce)
    begin
      i0_sync <= {i0_sync[0], ext_int0};
      i1_sync <= {i1_sync[0], ext_int1};
    end
  end

  // ********************************************************
  // AHB-Lite slave
  // ********************************************************
  assign ap = hsel && hready && htrans[1];

  always_comb
  begin
    rd_word = 32'h0000_0000;
    case (haddr[7:0])
      OFF_CMD:    rd_word = {16'h0000, arg_reg[7:0], 3'b000, op_reg};
      OFF_STATUS: rd_word = {31'h0000_0000, !idle};
      OFF_ACC:    rd_word = {24'h00_0000, a_reg};
      OFF_XREG:   rd_word = {24'h00_0000, x_reg};
      OFF_YREG:   rd_word = {24'h00_0000, y_reg};
      OFF_STKP:   rd_word = {24'h00_0000, stk_reg};
      OFF_PCNT:   rd_word = {16'h0000, pcnt_reg};
      OFF_FLAGS:  rd_word = {24'h00_0000, fl_reg};
      default:    rd_word = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_q      <= 1'b0;
      addr_q    <= 8'h00;
      hrdata    <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
    else if (ce)
    begin
      wr_q   <= ap && hwrite;
      addr_q <= haddr[7:0];
      if (ap && !hwrite)
        hrdata <= rd_word;
    end
  end

  // ********************************************************
  // Arithmetic
  // ********************************************************
  always_comb
  begin
    sum9   = {1'b0, a_reg} + {1'b0, arg8} + {8'h00, fl_reg[FL_C]};
    dif9   = {1'b0, a_reg} - {1'b0, arg8} - {8'h00, !fl_reg[FL_C]};
    lo_add = {1'b0, a_reg[3:0]} + {1'b0, arg8[3:0]} + {4'h0, fl_reg[FL_C]};
    lo_sub = {1'b0, a_reg[3:0]} - {1'b0, arg8[3:0]} - {4'h0, !fl_reg[FL_C]};
    prod   = {8'h00, y_reg} * {8'h00, a_reg};
    quo    = 16'h0000;
    rem    = 16'h0000;
    if (x_reg != 8'h00)
    begin
      quo = {y_reg, a_reg} / {8'h00, x_reg};
      rem = {y_reg, a_reg} % {8'h00, x_reg};
    end
  end

  // Stack push byte order: counter high, counter low, flags
  always_comb
  begin
    if (one_byte_reg)
      push_byte = a_reg;
    else if (idx_reg == 2'd0)
      push_byte = pcnt_reg[15:8];
    else if (idx_reg == 2'd1)
      push_byte = pcnt_reg[7:0];
    else
      push_byte = fl_reg;
  end

  // ********************************************************
  // Stack pointer: deliberately without reset
  // ********************************************************
  always_comb
  begin
    stk_next = stk_reg;
    if (ce && wr_q && addr_q == OFF_STKP && idle)
      stk_next = hwdata[7:0];
    if (adv && state_reg == ST_PUSH)
      stk_next = stk_reg - 8'h01;
    if (adv && state_reg == ST_POP_ADR)
      stk_next = stk_reg + 8'h01;
  end

  always_ff @(posedge hclk)
    stk_reg <= stk_next;

  // ********************************************************
  // Core sequencer and registers
  // ********************************************************
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      state_reg    <= ST_VEC_LO;
      vec_reg      <= RESET_VEC;
      pcnt_reg     <= RESET_VEC;
      a_reg        <= 8'h00;
      x_reg        <= 8'h00;
      y_reg        <= 8'h00;
      fl_reg       <= 8'h00;
      tgt_reg      <= 16'h0000;
      lo_reg       <= 8'h00;
      idx_reg      <= 2'd0;
      len_reg      <= 2'd0;
      one_byte_reg <= 1'b0;
      direct_reg   <= 1'b0;
      irq_reg      <= 1'b0;
      trap_reg     <= 1'b0;
      pend_reg     <= 1'b0;
      op_reg       <= OP_STEP;
      arg_reg      <= 16'h0000;
      pm_addr      <= 16'h0000;
      dm_addr      <= 16'h0000;
      dm_wdata     <= 8'h00;
      dm_we        <= 1'b0;
    end
    else if (ce)
    begin
      // Software writes only land while the sequencer is quiet
      if (wr_q && idle)
      begin
        case (addr_q)
          OFF_CMD:
          begin
            op_reg   <= hwdata[CMD_OP_LSB +: CMD_OP_W];
            arg_reg  <= hwdata[CMD_ARG_LSB +: CMD_ARG_W];
            pend_reg <= 1'b1;
          end
          OFF_ACC:   a_reg  <= hwdata[7:0];
          OFF_XREG:  x_reg  <= hwdata[7:0];
          OFF_YREG:  y_reg  <= hwdata[7:0];
          OFF_FLAGS: fl_reg <= hwdata[7:0];
          default:   ;
        endcase
      end
      if (adv)
      begin
        dm_we <= 1'b0;
        unique case (state_reg)
          ST_IDLE:
          begin
            // Interrupts are served ahead of a waiting command
            if (fl_reg[FL_I] && (i0_sync[1] || i1_sync[1]))
            begin
              vec_reg      <= i0_sync[1] ? INT0_VEC : INT1_VEC;
              len_reg      <= LAST_BYTE;
              idx_reg      <= 2'd0;
              one_byte_reg <= 1'b0;
              direct_reg   <= 1'b0;
              irq_reg      <= 1'b1;
              trap_reg     <= 1'b0;
              state_reg    <= ST_PUSH;
            end
            else if (pend_reg)
            begin
              pend_reg     <= 1'b0;
              idx_reg      <= 2'd0;
              one_byte_reg <= 1'b0;
              direct_reg   <= 1'b0;
              irq_reg      <= 1'b0;
              trap_reg     <= 1'b0;
              len_reg      <= 2'd1;
              case (op_reg)
                OP_STEP: pcnt_reg <= pcnt_reg + 16'h0001;
                OP_ADC:
                begin
                  a_reg        <= sum9[7:0];
                  fl_reg[FL_C] <= sum9[8];
                  fl_reg[FL_H] <= lo_add[4];
                  fl_reg[FL_V] <= (a_reg[7] == arg8[7]) && (sum9[7] != a_reg[7]);
                  fl_reg[FL_Z] <= sum9[7:0] == 8'h00;
                  fl_reg[FL_N] <= sum9[7];
                end
                OP_SBC:
                begin
                  a_reg        <= dif9[7:0];
                  fl_reg[FL_C] <= !dif9[8];
                  fl_reg[FL_H] <= !lo_sub[4];
                  fl_reg[FL_V] <= (a_reg[7] != arg8[7]) && (dif9[7] != a_reg[7]);
                  fl_reg[FL_Z] <= dif9[7:0] == 8'h00;
                  fl_reg[FL_N] <= dif9[7];
                end
                OP_LDA:
                begin
                  a_reg        <= arg8;
                  fl_reg[FL_Z] <= arg8 == 8'h00;
                  fl_reg[FL_N] <= arg8[7];
                end
                OP_ASL, OP_ROL:
                begin
                  a_reg        <= {a_reg[6:0], (op_reg == OP_ROL) && fl_reg[FL_C]};
                  fl_reg[FL_C] <= a_reg[7];
                  fl_reg[FL_Z] <= {a_reg[6:0], (op_reg == OP_ROL) && fl_reg[FL_C]} == 8'h00;
                  fl_reg[FL_N] <= a_reg[6];
                end
                OP_MUL:
                begin
                  {y_reg, a_reg} <= prod;
                  fl_reg[FL_Z]   <= prod == 16'h0000;
                  fl_reg[FL_N]   <= prod[15];
                end
                OP_DIV:
                begin
                  // Zero divisor or oversized quotient leaves the pair and sets overflow
                  if (x_reg != 8'h00 && quo[15:8] == 8'h00)
                  begin
                    a_reg        <= quo[7:0];
                    y_reg        <= rem[7:0];
                    fl_reg[FL_Z] <= quo[7:0] == 8'h00;
                    fl_reg[FL_N] <= quo[7];
                  end
                  else
                    fl_reg[FL_V] <= 1'b1;
                end
                OP_BIT:
                begin
                  dm_addr   <= {7'h00, fl_reg[FL_G], arg8};
                  state_reg <= ST_BIT_DAT;
                end
                OP_PUSH:
                begin
                  one_byte_reg <= 1'b1;
                  len_reg      <= 2'd0;
                  state_reg    <= ST_PUSH;
                end
                OP_POP:
                begin
                  one_byte_reg <= 1'b1;
                  state_reg    <= ST_POP_ADR;
                end
                OP_CALL, OP_PGCALL:
                begin
                  tgt_reg    <= (op_reg == OP_CALL) ? arg_reg : {PAGECALL_PG, arg8};
                  direct_reg <= 1'b1;
                  state_reg  <= ST_PUSH;
                end
                OP_TBCALL:
                begin
                  vec_reg   <= TBL0_VEC - {11'h000, arg_reg[3:0], 1'b0};
                  state_reg <= ST_PUSH;
                end
                OP_TRAP:
                begin
                  vec_reg   <= TRAP_VEC;
                  len_reg   <= LAST_BYTE;
                  trap_reg  <= 1'b1;
                  state_reg <= ST_PUSH;
                end
                OP_RET:
                begin
                  idx_reg   <= 2'd1;
                  state_reg <= ST_POP_ADR;
                end
                OP_RETI:  state_reg <= ST_POP_ADR;
                OP_UNMASK: fl_reg[FL_I] <= 1'b1;
                OP_MASK:   fl_reg[FL_I] <= 1'b0;
                OP_VCLR:   {fl_reg[FL_V], fl_reg[FL_H]} <= 2'b00;
                OP_PG1:    fl_reg[FL_G] <= 1'b1;
                OP_PG0:    fl_reg[FL_G] <= 1'b0;
                default:  ;
              endcase
            end
          end
          ST_PUSH:
          begin
            dm_addr  <= {STACK_PAGE, stk_reg};
            dm_wdata <= push_byte;
            dm_we    <= 1'b1;
            idx_reg  <= idx_reg + 2'd1;
            if (idx_reg == len_reg)
            begin
              if (one_byte_reg)
                state_reg <= ST_IDLE;
              else if (direct_reg)
              begin
                pcnt_reg  <= tgt_reg;
                state_reg <= ST_IDLE;
              end
              else
              begin
                if (irq_reg || trap_reg)
                  fl_reg[FL_I] <= 1'b0;
                if (trap_reg)
                  fl_reg[FL_B] <= 1'b1;
                state_reg <= ST_VEC_LO;
              end
            end
          end
          ST_POP_ADR:
          begin
            dm_addr   <= {STACK_PAGE, stk_reg + 8'h01};
            state_reg <= ST_POP_DAT;
          end
          ST_POP_DAT:
          begin
            idx_reg <= idx_reg + 2'd1;
            if (one_byte_reg)
              a_reg <= dm_rdata;
            else if (idx_reg == 2'd0)
              fl_reg <= dm_rdata;
            else if (idx_reg == 2'd1)
              pcnt_reg[7:0] <= dm_rdata;
            else
              pcnt_reg[15:8] <= dm_rdata;
            if (one_byte_reg || idx_reg == LAST_BYTE)
              state_reg <= ST_IDLE;
            else
              state_reg <= ST_POP_ADR;
          end
          ST_BIT_DAT:
          begin
            fl_reg[FL_V] <= dm_rdata[6];
            fl_reg[FL_N] <= dm_rdata[7];
            state_reg    <= ST_IDLE;
          end
          ST_VEC_LO:
          begin
            pm_addr   <= vec_reg;
            state_reg <= ST_VEC_HI;
          end
          ST_VEC_HI:
          begin
            lo_reg    <= pm_rdata;
            pm_addr   <= vec_reg + 16'h0001;
            state_reg <= ST_VEC_END;
          end
          ST_VEC_END:
          begin
            pcnt_reg  <= {pm_rdata, lo_reg};
            state_reg <= ST_IDLE;
          end
        endcase
      end
    end
  end

endmodule

// ### dv/core_mem_model.sv
// Purpose: Program and data memory beside the core
// Assumes: Combinational reads, data writes on hclk
// Notes:   Even program bytes follow the address, odd ones read 8'h40, so every vector is known
`timescale 1ns/1ps

module core_mem_model
(
  input  wire logic        hclk,
  input  wire logic [15:0] pm_addr,
  output logic      [7:0]  pm_rdata,
  input  wire logic [15:0] dm_addr,
  input  wire logic [7:0]  dm_wdata,
  input  wire logic        dm_we,
  output logic      [7:0]  dm_rdata
);
  logic [7:0] ram [512];

  // Read only: no write path exists into program space
  assign pm_rdata = pm_addr[0] ? 8'h40 : pm_addr[7:0];
  assign dm_rdata = ram[dm_addr[8:0]];

  initial
  begin
    for (int i = 0; i < 512; i++)
      ram[i] = i[7:0] ^ (i[8] ? 8'h80 : 8'hc3);
  end

  always @(posedge hclk)
  begin
    if (dm_we)
      ram[dm_addr[8:0]] <= dm_wdata;
  end
endmodule

// ### dv/core_regs_assertions.sv
// Purpose: Port checks for the core register and flag unit
// Assumes: Clock enable high during boot
// Notes:   Sees only the ports of the top module
`timescale 1ns/1ps

module core_regs_assertions
  import core_regs_pkg::*;
(
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        ce,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic [15:0] pm_addr,
  input wire logic [15:0] dm_addr,
  input wire logic        dm_we
);
  logic [2:0] boot_cnt;

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  // Saturates so only the boot fetch is looked at
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      boot_cnt <= 3'd0;
    else if (ce && boot_cnt != 3'd7)
      boot_cnt <= boot_cnt + 3'd1;
  end

  // Sequencer steps on the second enabled edge after release, then every other one
  property p_vec_lo;
    boot_cnt == 3'd2 |-> pm_addr == RESET_VEC;
  endproperty
  a_vec_lo: assert property (p_vec_lo) else $error("boot low fetch");

  property p_vec_hi;
    boot_cnt == 3'd4 |-> pm_addr == 16'hffff;
  endproperty
  a_vec_hi: assert property (p_vec_hi) else $error("boot high fetch");

  property p_stack_pg;
    dm_we |-> dm_addr[15:8] == STACK_PAGE;
  endproperty
  a_stack_pg: assert property (p_stack_pg) else $error("stack page");

  property p_push_dec;
    dm_we && $past(dm_we) && $changed(dm_addr)
      |-> dm_addr[7:0] == $past(dm_addr[7:0]) - 8'h01;
  endproperty
  a_push_dec: assert property (p_push_dec) else $error("push order");

  property p_we_two;
    $rose(dm_we) |=> dm_we;
  endproperty
  a_we_two: assert property (p_we_two) else $error("write too short");

  property p_pm_hold;
    $changed(pm_addr) |=> $stable(pm_addr);
  endproperty
  a_pm_hold: assert property (p_pm_hold) else $error("fetch pace");

  property p_dm_hold;
    dm_we && $changed(dm_addr) |=> $stable(dm_addr);
  endproperty
  a_dm_hold: assert property (p_dm_hold) else $error("write pace");

  property p_freeze;
    !ce |=> $stable(pm_addr) && $stable(dm_addr) && $stable(dm_we);
  endproperty
  a_freeze: assert property (p_freeze) else $error("moved while held");

  property p_okay;
    hreadyout && !hresp;
  endproperty
  a_okay: assert property (p_okay) else $error("bus not ready or error");

  cover property ($rose(dm_we));
  cover property (dm_we && $past(dm_we) && $changed(dm_addr));
  cover property (pm_addr == INT0_VEC);
endmodule

bind cpu_core_regs core_regs_assertions core_regs_assertions_i (
  .hclk(hclk), .hresetn(hresetn), .ce(ce), .hreadyout(hreadyout),
  .hresp(hresp), .pm_addr(pm_addr), .dm_addr(dm_addr), .dm_we(dm_we));

// ### dv/tb.sv
// Purpose: Self-checking bench for the core register and flag unit
// Assumes: Zero wait AHB-Lite slave, memory model on the far side
// Notes:   Polls busy after each command instead of counting cycles
`timescale 1ns/1ps

module tb
  import core_regs_pkg::*;
;
  logic        hclk, hresetn, ce, hsel, hwrite, hreadyout, hresp, dm_we;
  logic [1:0]  htrans, irq;
  logic [31:0] haddr, hwdata, hrdata, q;
  logic [15:0] pm_addr, dm_addr;
  logic [7:0]  pm_rdata, dm_wdata, dm_rdata;
  int          err_total, check_count;

  cpu_core_regs cpu_core_regs_i (
    .hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .pm_addr(pm_addr), .pm_rdata(pm_rdata), .dm_addr(dm_addr), .dm_wdata(dm_wdata),
    .dm_we(dm_we), .dm_rdata(dm_rdata), .ext_int0(irq[0]), .ext_int1(irq[1]));

  core_mem_model core_mem_model_i (
    .hclk(hclk), .pm_addr(pm_addr), .pm_rdata(pm_rdata), .dm_addr(dm_addr),
    .dm_wdata(dm_wdata), .dm_we(dm_we), .dm_rdata(dm_rdata));

  // ****************************************
  // Clock, watchdog and checking
  // ****************************************
  initial
  begin
    hclk = 1'b0;
    forever #4 hclk = ~hclk;
  end

  initial
  begin
    repeat (40000) @(posedge hclk);
    err_total++;
    conclude();
  end

  task automatic conclude();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      err_total++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // ****************************************
  // Bus cycles and commands
  // ****************************************
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr <= {24'h0, a};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d, q);
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0, q);
    chk(q, e);
  endtask

  // Commands are refused while busy, so wait for idle every time
  task automatic idle();
    do bus(1'b0, OFF_STATUS, 32'h0, q); while (q[0] !== 1'b0);
  endtask

  task automatic run(input logic [4:0] op, input logic [15:0] arg);
    wr(OFF_CMD, {8'h00, arg, 3'b000, op});
    idle();
  endtask

  task automatic alu(input logic [7:0] f, a, input logic [4:0] op,
                     input logic [7:0] g, ea, ef);
    wr(OFF_FLAGS, {24'h0, f});
    wr(OFF_ACC, {24'h0, a});
    run(op, {8'h00, g});
    rchk(OFF_ACC, {24'h0, ea});
    rchk(OFF_FLAGS, {24'h0, ef});
  endtask

  // ****************************************
  // Tests
  // ****************************************
  initial
  begin
    {hsel, hwrite, htrans, haddr, hwdata, irq} = '0;
    {err_total, check_count} = '0;
    ce = 1'b1;
    hresetn = 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    idle();
    rchk(OFF_PCNT, 32'h40fe);
    wr(8'h40, 32'hff);
    rchk(8'h40, 32'h0);
    $display("boot test done");
    alu(8'h00, 8'h00, OP_LDA, 8'h00, 8'h00, 8'h02);
    alu(8'h00, 8'h00, OP_LDA, 8'h80, 8'h80, 8'h80);
    alu(8'h00, 8'h7f, OP_ADC, 8'h01, 8'h80, 8'hc8);
    alu(8'h00, 8'hff, OP_ADC, 8'h01, 8'h00, 8'h0b);
    alu(8'h01, 8'h10, OP_SBC, 8'h01, 8'h0f, 8'h01);
    alu(8'h01, 8'h00, OP_SBC, 8'h01, 8'hff, 8'h80);
    alu(8'h00, 8'h80, OP_SBC, 8'h00, 8'h7f, 8'h41);
    alu(8'h00, 8'h81, OP_ASL, 8'h00, 8'h02, 8'h01);
    alu(8'h01, 8'h40, OP_ROL, 8'h00, 8'h81, 8'h80);
    alu(8'h48, 8'h00, OP_VCLR, 8'h00, 8'h00, 8'h00);
    alu(8'h00, 8'h00, OP_UNMASK, 8'h00, 8'h00, 8'h04);
    alu(8'hff, 8'h00, OP_MASK, 8'h00, 8'h00, 8'hfb);
    alu(8'h00, 8'h00, OP_PG1, 8'h00, 8'h00, 8'h20);
    alu(8'h20, 8'h00, OP_PG0, 8'h00, 8'h00, 8'h00);
    alu(8'h00, 8'h00, OP_BIT, 8'h10, 8'h00, 8'hc0);
    alu(8'h20, 8'h00, OP_BIT, 8'h10, 8'h00, 8'ha0);
    wr(OFF_YREG, 32'h12);
    wr(OFF_ACC, 32'h34);
    run(OP_MUL, 16'h0);
    rchk(OFF_ACC, 32'ha8);
    rchk(OFF_YREG, 32'h03);
    wr(OFF_YREG, 32'h01);
    wr(OFF_ACC, 32'h00);
    wr(OFF_XREG, 32'h07);
    run(OP_DIV, 16'h0);
    rchk(OFF_ACC, 32'h24);
    rchk(OFF_YREG, 32'h04);
    $display("alu test done");
    wr(OFF_STKP, 32'hff);
    wr(OFF_ACC, 32'h5a);
    run(OP_PUSH, 16'h0);
    rchk(OFF_STKP, 32'hfe);
    chk({24'h0, core_mem_model_i.ram[9'h1ff]}, 32'h5a);
    wr(OFF_ACC, 32'h0);
    run(OP_POP, 16'h0);
    rchk(OFF_ACC, 32'h5a);
    rchk(OFF_STKP, 32'hff);
    run(OP_CALL, 16'h1234);
    run(OP_CALL, 16'hffff);
    chk({24'h0, core_mem_model_i.ram[9'h1fd]}, 32'h12);
    run(OP_STEP, 16'h0);
    rchk(OFF_PCNT, 32'h0);
    wr(OFF_FLAGS, 32'h03);
    run(OP_RET, 16'h0);
    rchk(OFF_PCNT, 32'h1234);
    rchk(OFF_FLAGS, 32'h03);
    run(OP_PGCALL, 16'h0035);
    rchk(OFF_PCNT, 32'hff35);
    run(OP_RET, 16'h0);
    for (int n = 0; n < 16; n++)
    begin
      run(OP_TBCALL, 16'(n));
      rchk(OFF_PCNT, 32'h40de - 32'(2 * n));
      run(OP_RET, 16'h0);
    end
    rchk(OFF_STKP, 32'hfd);
    wr(OFF_FLAGS, 32'h04);
    run(OP_TRAP, 16'h0);
    rchk(OFF_PCNT, 32'h40de);
    rchk(OFF_FLAGS, 32'h10);
    rchk(OFF_STKP, 32'hfa);
    chk({24'h0, core_mem_model_i.ram[9'h1fb]}, 32'h04);
    run(OP_RETI, 16'h0);
    rchk(OFF_FLAGS, 32'h04);
    rchk(OFF_PCNT, 32'h1234);
    $display("stack test done");
    for (int k = 0; k < 3; k++)
    begin
      if (k == 2)
        run(OP_MASK, 16'h0);
      irq <= (k == 1) ? 2'b10 : 2'b01;
      repeat (40) @(posedge hclk);
      irq <= 2'b00;
      idle();
      rchk(OFF_PCNT, (k == 2) ? 32'h1234 : (k == 1) ? 32'h40f8 : 32'h40fa);
      if (k < 2)
      begin
        rchk(OFF_FLAGS, 32'h0);
        run(OP_RETI, 16'h0);
      end
    end
    ce <= 1'b0;
    repeat (6) @(posedge hclk);
    ce <= 1'b1;
    rchk(OFF_PCNT, 32'h1234);
    $display("interrupt test done");
    conclude();
  end
endmodule
